// ==== core/ssa_params.svh ====
// constants for the special status word area: word indices, field positions, timing
// assumes inclusion by name from the package; the top module uses its macros without including it
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH

// ==========================================================
// word indices (byte address is four times the index)
`define SSA_IDX_FIRST        10'h0ec
`define SSA_IDX_LAST         10'h12b
`define SSA_IDX_SEC2         10'h100
`define SSA_IDX_NODE_LOOP    10'h0ec
`define SSA_IDX_COMPLETION   10'h0ed
`define SSA_IDX_DL0          10'h0ee
`define SSA_IDX_DL1          10'h0f2
`define SSA_IDX_UNUSED       10'h0f6
`define SSA_IDX_LINK_HI      10'h0f7
`define SSA_IDX_LINK_LO      10'h0f9
`define SSA_IDX_RIO          10'h0fb
`define SSA_IDX_UNIT_ERR     10'h0fd
`define SSA_IDX_PULSE_ARITH  10'h0ff
`define SSA_IDX_IRQ_TIME     10'h106
`define SSA_IDX_IRQ_NUM      10'h107
`define SSA_IDX_SERIAL       10'h108
`define SSA_IDX_RESTART      10'h12a

// ==========================================================
// field positions
`define SSA_RIO_READ_BIT     0
`define SSA_RIO_FLAG_BIT     3
`define SSA_RIO_RACK_LSB     4
`define SSA_RIO_MASTER_LSB   8
`define SSA_ARITH_LSB        3
`define SSA_GRP2_ERR_BIT     14
`define SSA_SPEC_ERR_BIT     15
`define SSA_IRQ_NUM_DIGIT    4'h8

// ==========================================================
// reset values and timing
`define SSA_RESET_WORD       16'h0000
`define SSA_CLK_PERIOD_NS    10
`define SSA_PULSE_HALF_MS    50
`define SSA_IRQ_UNIT_US      100
`define SSA_SEC2_WAIT        2'd1

`endif

// ==== core/ssa_pkg.sv ====
// types of the special status word area
// assumes ssa_params.svh on the include path
`include "ssa_params.svh"

package ssa_pkg;

   // ==========================================================
   // bus carriers
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } ssa_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ssa_apb_rsp_t;

   // ==========================================================
   // firmware side carriers
   typedef struct packed {
      logic [4:0] arith_set;      // pulse: error, carry, greater, equal, less
      logic       end_of_program; // pulse
      logic       irq_active;     // level while an interrupt subroutine runs
      logic [7:0] irq_id;         // subroutine number 0..255
      logic [3:0] serial_err;     // serial port error code
   } ssa_exec_t;

   typedef struct packed {
      logic [15:0] node_loop;     // level 1 high byte, level 0 low byte
      logic [1:0]  done;          // pulse per operating level
      logic [15:0] done_code;     // code per level, same layout
      logic [63:0] dl0;           // data link status, level 0
      logic [63:0] dl1;           // data link status, level 1
      logic [31:0] run;           // link unit run flags
      logic [31:0] err;           // link unit error flags
      logic        grp2_err;
      logic        spec_err;
   } ssa_link_t;

   typedef struct packed {
      logic       fault;          // pulse on a remote i/o fault
      logic [2:0] rack;
      logic [7:0] master;
   } ssa_rio_t;

endpackage : ssa_pkg

// ==== core/ssa_pulse_gen.sv ====
// free running clock pulse bits of 0.1 s, 0.2 s and 1.0 s period
// assumes one clock, asynchronous active low reset
`timescale 1ns/1ps

module ssa_pulse_gen #(
   parameter int TICK_CYCLES = `SSA_PULSE_HALF_MS * 1000000 / `SSA_CLK_PERIOD_NS
) (
   input  wire logic       pclk,     // system clock
   input  wire logic       presetn,  // async reset, active low
   output logic [2:0]      pulse     // 0.1 s, 0.2 s, 1.0 s
);
   import ssa_pkg::*;

   localparam int CW = $clog2(TICK_CYCLES + 1);

   generate
      if (TICK_CYCLES < 1) begin : g_bad
         $error("ssa_pulse_gen: TICK_CYCLES must be at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [CW-1:0] tick;
      logic [3:0]    tens;
      logic          two;
      logic [2:0]    pulse;
   } ssa_pg_state_t;

   ssa_pg_state_t s_q;
   ssa_pg_state_t s_d;

   // ==========================================================
   // half period base tick, each bit toggles on whole half periods
   always_comb begin
      s_d = s_q;
      if (s_q.tick == CW'(TICK_CYCLES - 1)) begin
         s_d.tick     = '0;
         s_d.pulse[0] = ~s_q.pulse[0];
         s_d.two      = ~s_q.two;
         if (s_q.two) begin
            s_d.pulse[1] = ~s_q.pulse[1];
         end
         if (s_q.tens == 4'h9) begin
            s_d.tens     = 4'h0;
            s_d.pulse[2] = ~s_q.pulse[2];
         end else begin
            s_d.tens = s_q.tens + 4'h1;
         end
      end else begin
         s_d.tick = s_q.tick + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pulse = s_q.pulse;

endmodule : ssa_pulse_gen

// ==== core/ssa_top.sv ====
// special status word area: apb register bank of controller status words
// assumes apb master on pclk; firmware event inputs on the same clock
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module ssa_top #(
   parameter int PULSE_TICK_CYCLES = `SSA_PULSE_HALF_MS * 1000000 / `SSA_CLK_PERIOD_NS,
   parameter int IRQ_UNIT_CYCLES   = `SSA_IRQ_UNIT_US * 1000 / `SSA_CLK_PERIOD_NS
) (
   input  wire logic               pclk,         // system clock
   input  wire logic               presetn,      // async reset, active low
   input  wire ssa_pkg::ssa_apb_req_t apb_req,   // apb request
   output ssa_pkg::ssa_apb_rsp_t   apb_rsp,      // apb answer
   input  wire ssa_pkg::ssa_exec_t exec_in,      // execution engine events
   input  wire ssa_pkg::ssa_link_t link_in,      // link and network status
   input  wire ssa_pkg::ssa_rio_t  rio_in,       // remote i/o fault report
   output logic [15:0]             link_restart  // restart pulse per link unit
);
   import ssa_pkg::*;

   generate
      if (IRQ_UNIT_CYCLES < 1 || IRQ_UNIT_CYCLES > 65535) begin : g_bad
         $error("ssa_top: IRQ_UNIT_CYCLES out of range 1..65535");
      end
   endgenerate

   // ==========================================================
   // helpers
   function automatic logic in_area(input logic [9:0] idx);
      in_area = (idx >= `SSA_IDX_FIRST) && (idx <= `SSA_IDX_LAST);
   endfunction : in_area

   function automatic logic [11:0] to_bcd(input logic [7:0] bin);
      logic [19:0] sh;
      sh = {12'h000, bin};
      for (int i = 0; i < 8; i++) begin
         if (sh[11:8] > 4'd4) begin
            sh[11:8] = sh[11:8] + 4'd3;
         end
         if (sh[15:12] > 4'd4) begin
            sh[15:12] = sh[15:12] + 4'd3;
         end
         if (sh[19:16] > 4'd4) begin
            sh[19:16] = sh[19:16] + 4'd3;
         end
         sh = {sh[18:0], 1'b0};
      end
      to_bcd = sh[19:8];
   endfunction : to_bcd

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0]  strb);
      merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction : merge

   // ==========================================================
   // state
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } ssa_bus_st_t;

   typedef struct packed {
      ssa_bus_st_t bus;
      logic [1:0]  wait_cnt;
      logic [31:0] rdata;
      logic        slverr;
      logic [15:0] comp_code;
      logic [15:0] rio;
      logic [4:0]  arith;
      logic [15:0] irq_max;
      logic [15:0] irq_num;
      logic [15:0] irq_cur;
      logic [15:0] irq_sub;
      logic        irq_prev;
      logic [15:0] restart;
      logic [15:0] restart_pulse;
   } ssa_state_t;

   ssa_state_t s_q;
   ssa_state_t s_d;

   logic [2:0]  pulse;
   logic [9:0]  idx;
   logic        setup;
   logic        access;
   logic        fire;
   logic [15:0] word_rd;
   logic [15:0] new_restart;

   ssa_pulse_gen #(
      .TICK_CYCLES (PULSE_TICK_CYCLES)
   ) u_pulse (
      .pclk    (pclk),
      .presetn (presetn),
      .pulse   (pulse)
   );

   assign idx    = apb_req.paddr[11:2];
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign fire   = access & (s_q.bus == ST_DONE);

   // ==========================================================
   // read mux
   always_comb begin
      word_rd = `SSA_RESET_WORD;
      case (idx)
         `SSA_IDX_NODE_LOOP:          word_rd = link_in.node_loop;
         `SSA_IDX_COMPLETION:         word_rd = s_q.comp_code;
         `SSA_IDX_DL0:                word_rd = link_in.dl0[15:0];
         `SSA_IDX_DL0 + 10'h001:      word_rd = link_in.dl0[31:16];
         `SSA_IDX_DL0 + 10'h002:      word_rd = link_in.dl0[47:32];
         `SSA_IDX_DL0 + 10'h003:      word_rd = link_in.dl0[63:48];
         `SSA_IDX_DL1:                word_rd = link_in.dl1[15:0];
         `SSA_IDX_DL1 + 10'h001:      word_rd = link_in.dl1[31:16];
         `SSA_IDX_DL1 + 10'h002:      word_rd = link_in.dl1[47:32];
         `SSA_IDX_DL1 + 10'h003:      word_rd = link_in.dl1[63:48];
         `SSA_IDX_LINK_HI:            word_rd = {link_in.err[23:16], link_in.run[23:16]};
         `SSA_IDX_LINK_HI + 10'h001:  word_rd = {link_in.err[31:24], link_in.run[31:24]};
         `SSA_IDX_LINK_LO:            word_rd = {link_in.err[7:0], link_in.run[7:0]};
         `SSA_IDX_LINK_LO + 10'h001:  word_rd = {link_in.err[15:8], link_in.run[15:8]};
         `SSA_IDX_RIO:                word_rd = s_q.rio;
         `SSA_IDX_UNIT_ERR: begin
            word_rd[`SSA_GRP2_ERR_BIT] = link_in.grp2_err;
            word_rd[`SSA_SPEC_ERR_BIT] = link_in.spec_err;
         end
         `SSA_IDX_PULSE_ARITH: begin
            // high byte holds branch storage and reads zero
            word_rd = {8'h00, s_q.arith, pulse};
         end
         `SSA_IDX_IRQ_TIME:           word_rd = s_q.irq_max;
         `SSA_IDX_IRQ_NUM:            word_rd = s_q.irq_num;
         `SSA_IDX_SERIAL:             word_rd = {12'h000, exec_in.serial_err};
         `SSA_IDX_RESTART:            word_rd = s_q.restart;
         default:                     word_rd = `SSA_RESET_WORD;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      new_restart = s_q.restart;

      // bus sequencing: answer is prepared in setup, second section waits
      case (s_q.bus)
         ST_IDLE: begin
            if (setup) begin
               s_d.rdata  = {16'h0000, word_rd};
               s_d.slverr = ~in_area(idx);
               if (in_area(idx) && idx >= `SSA_IDX_SEC2) begin
                  s_d.wait_cnt = `SSA_SEC2_WAIT;
                  s_d.bus      = ST_WAIT;
               end else begin
                  s_d.bus = ST_DONE;
               end
            end
         end
         ST_WAIT: begin
            if (s_q.wait_cnt <= 2'd1) begin
               s_d.wait_cnt = 2'd0;
               s_d.bus      = ST_DONE;
            end else begin
               s_d.wait_cnt = s_q.wait_cnt - 2'd1;
            end
         end
         ST_DONE: begin
            if (fire) begin
               s_d.bus = ST_IDLE;
            end
         end
         default: s_d.bus = ST_IDLE;
      endcase

      // remote i/o: fault latches fields, read request refreshes them
      if (rio_in.fault) begin
         s_d.rio[`SSA_RIO_FLAG_BIT] = 1'b1;
         s_d.rio[`SSA_RIO_RACK_LSB +: 3]   = rio_in.rack;
         s_d.rio[`SSA_RIO_MASTER_LSB +: 8] = rio_in.master;
      end
      if (s_q.rio[`SSA_RIO_READ_BIT]) begin
         s_d.rio[`SSA_RIO_READ_BIT]        = 1'b0;
         s_d.rio[`SSA_RIO_RACK_LSB +: 3]   = rio_in.rack;
         s_d.rio[`SSA_RIO_MASTER_LSB +: 8] = rio_in.master;
      end

      // user writes: only the read request bit and the restart word accept data
      if (fire && apb_req.pwrite && !s_q.slverr) begin
         if (idx == `SSA_IDX_RIO && apb_req.pstrb[0]) begin
            s_d.rio[`SSA_RIO_READ_BIT] = apb_req.pwdata[`SSA_RIO_READ_BIT];
         end
         if (idx == `SSA_IDX_RESTART) begin
            new_restart = merge(s_q.restart, apb_req.pwdata[15:0],
                                apb_req.pstrb[1:0]);
         end
      end
      s_d.restart       = new_restart;
      s_d.restart_pulse = s_q.restart & ~new_restart;

      // arithmetic flags: end of program clears, a set in that cycle wins
      if (exec_in.end_of_program) begin
         s_d.arith = 5'h00;
      end
      s_d.arith = s_d.arith | exec_in.arith_set;

      // completion codes per operating level
      if (link_in.done[0]) begin
         s_d.comp_code[7:0] = link_in.done_code[7:0];
      end
      if (link_in.done[1]) begin
         s_d.comp_code[15:8] = link_in.done_code[15:8];
      end

      // interrupt subroutine timing in 0.1 ms units, saturating
      s_d.irq_prev = exec_in.irq_active;
      if (exec_in.irq_active) begin
         if (!s_q.irq_prev) begin
            s_d.irq_cur = 16'h0000;
            s_d.irq_sub = 16'h0000;
         end else if (s_q.irq_sub == 16'(IRQ_UNIT_CYCLES - 1)) begin
            s_d.irq_sub = 16'h0000;
            if (s_q.irq_cur != 16'hffff) begin
               s_d.irq_cur = s_q.irq_cur + 16'h0001;
            end
         end else begin
            s_d.irq_sub = s_q.irq_sub + 16'h0001;
         end
      end else if (s_q.irq_prev && (s_q.irq_cur > s_q.irq_max ||
                                    !s_q.irq_num[15])) begin
         s_d.irq_max = s_q.irq_cur;
         s_d.irq_num = {`SSA_IRQ_NUM_DIGIT, to_bcd(exec_in.irq_id)};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q     <= '0;
         s_q.bus <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   always_comb begin
      apb_rsp.prdata  = s_q.rdata;
      apb_rsp.pready  = access & (s_q.bus == ST_DONE);
      apb_rsp.pslverr = access & (s_q.bus == ST_DONE) & s_q.slverr;
   end

   assign link_restart = s_q.restart_pulse;

endmodule : ssa_top

// ==== verif/ssa_monitor.sv ====
// checker of bus answers and restart pulses of the special status word area
// assumes it is bound to ssa_top and sees only the top module's ports
`timescale 1ns/1ps

module ssa_monitor #(
   parameter int PULSE_TICK_CYCLES = 5,
   parameter int IRQ_UNIT_CYCLES   = 4
) (
   input wire logic                  pclk,         // system clock
   input wire logic                  presetn,      // async reset, active low
   input wire ssa_pkg::ssa_apb_req_t apb_req,      // apb request
   input wire ssa_pkg::ssa_apb_rsp_t apb_rsp,      // apb answer
   input wire ssa_pkg::ssa_exec_t    exec_in,      // execution events
   input wire ssa_pkg::ssa_link_t    link_in,      // link status
   input wire ssa_pkg::ssa_rio_t     rio_in,       // remote i/o report
   input wire logic [15:0]           link_restart  // restart pulses
);
   import ssa_pkg::*;

   // ==========================================================
   // helpers
   logic [9:0] idx;
   logic       acc;
   logic       inr;
   logic       sec2;
   logic       rd_ok;
   logic       wr_rst;
   assign idx    = apb_req.paddr[11:2];
   assign acc    = apb_req.psel && apb_req.penable;
   assign inr    = idx >= 10'h0ec && idx <= 10'h12b;
   assign sec2   = idx >= 10'h100 && idx <= 10'h12b;
   assign rd_ok  = acc && apb_rsp.pready && !apb_req.pwrite;
   assign wr_rst = acc && apb_rsp.pready && apb_req.pwrite && idx == 10'h12a;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // assertions
   a_unmapped_err: assert property (
      acc && !inr |-> apb_rsp.pready && apb_rsp.pslverr)
      else $error("unmapped word not refused");
   a_mapped_noerr: assert property (
      acc && inr |-> !apb_rsp.pslverr)
      else $error("mapped word refused");
   a_idle_quiet: assert property (
      !acc |-> !apb_rsp.pready && !apb_rsp.pslverr)
      else $error("answer outside access phase");
   a_sec1_fast: assert property (
      acc && !$past(apb_req.penable) && inr && !sec2 |-> apb_rsp.pready)
      else $error("first section access not immediate");
   a_sec2_wait: assert property (
      acc && !$past(apb_req.penable) && sec2 |-> !apb_rsp.pready ##1 apb_rsp.pready)
      else $error("second section access without one wait");
   a_rsvd_zero: assert property (
      rd_ok && idx >= 10'h100 && idx <= 10'h105 |-> apb_rsp.prdata == 32'h0000_0000)
      else $error("reserved word not zero");
   a_branch_hidden: assert property (
      rd_ok && idx == 10'h0ff |-> apb_rsp.prdata[31:8] == 24'h00_0000)
      else $error("branch storage bits visible");
   a_pulse_single: assert property (
      link_restart != 16'h0000 |=> link_restart == 16'h0000)
      else $error("restart pulse longer than one cycle");
   a_restart_cause: assert property (
      link_restart != 16'h0000 |-> $past(wr_rst) || $past(wr_rst, 2))
      else $error("restart pulse without restart write");
endmodule : ssa_monitor

bind ssa_top ssa_monitor #(
   .PULSE_TICK_CYCLES(PULSE_TICK_CYCLES),
   .IRQ_UNIT_CYCLES(IRQ_UNIT_CYCLES)
) u_mon (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .exec_in(exec_in), .link_in(link_in), .rio_in(rio_in), .link_restart(link_restart)
);

// ==== verif/tb.sv ====
// self-checking bench of the special status word area driven over apb
// assumes the design package and top module are compiled before it
`timescale 1ns/1ps

module tb;
   import ssa_pkg::*;
   localparam int TICK = 5;
   localparam int UNIT = 4;
   logic         pclk;
   logic         presetn;
   ssa_apb_req_t req;
   ssa_apb_rsp_t rsp;
   ssa_exec_t    ex;
   ssa_link_t    lk;
   ssa_rio_t     rio;
   logic [15:0]  restart;
   logic [15:0]  seen;
   int           pulses;
   int           bad_count;
   int           num_checks;

   ssa_top #(.PULSE_TICK_CYCLES(TICK), .IRQ_UNIT_CYCLES(UNIT)) u_dut (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .exec_in(ex), .link_in(lk), .rio_in(rio), .link_restart(restart));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // collects restart pulses
   always @(posedge pclk) begin
      seen |= restart;
      pulses += $countones(restart);
   end

   // ==========================================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err, output int n);
      req.paddr  <= {idx, 2'b00};
      req.psel   <= 1'b1;
      req.pwrite <= wr;
      req.pwdata <= {16'h0000, wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      rd = rsp.prdata[15:0];
      err = rsp.pslverr;
      if (n >= 50) begin
         bad_count++;
         $display("unexpected at %0t: no bus answer", $time);
      end
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rc(input logic [9:0] idx, input logic [15:0] exp);
      logic [15:0] rd;
      logic        err;
      int          n;
      apb(1'b0, idx, 16'h0000, rd, err, n);
      chk(rd, exp);
   endtask : rc

   function automatic logic [15:0] bcd(input logic [7:0] b);
      return {4'h0, 4'(b / 100), 4'(b / 10 % 10), 4'(b % 10)};
   endfunction : bcd

   function automatic logic [15:0] near(input int a, input int b, input int tol);
      return 16'(a - b <= tol && b - a <= tol);
   endfunction : near

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [15:0] rd, v, w, mx, mn;
      logic        err;
      logic [2:0]  last;
      int          n, u, t0, hi;
      int          tg[3];
      req = '0;
      req.pstrb = 4'h3;
      ex = '0;
      lk = '0;
      rio = '0;
      presetn = 1'b0;
      seen = 16'h0000;
      pulses = 0;
      bad_count = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(32'h22706d83));
      @(posedge pclk);
      for (int i = 236; i <= 299; i++) begin
         apb(1'b0, 10'(i), 16'h0000, rd, err, n);
         chk(i == 255 ? rd & 16'hfff8 : rd, 16'h0000);
         chk({15'h0, err}, 16'h0000);
         chk(16'(n), i >= 256 ? 16'd2 : 16'd1);
      end
      apb(1'b0, 10'h0eb, 16'h0000, rd, err, n);
      chk({15'h0, err}, 16'h0001);
      apb(1'b1, 10'h12c, 16'hffff, rd, err, n);
      chk({15'h0, err}, 16'h0001);
      repeat (3) begin
         lk.dl0 <= {$urandom, $urandom};
         lk.dl1 <= {$urandom, $urandom};
         lk.node_loop <= 16'($urandom);
         lk.run <= $urandom;
         lk.err <= $urandom;
         lk.grp2_err <= 1'($urandom);
         lk.spec_err <= 1'($urandom);
         ex.serial_err <= 4'($urandom);
         repeat (2) @(posedge pclk);
         rc(10'h0ec, lk.node_loop);
         apb(1'b1, 10'h0ec, ~lk.node_loop, rd, err, n);
         rc(10'h0ec, lk.node_loop);
         for (int k = 0; k < 4; k++) begin
            rc(10'(k < 2 ? 249 + k : 245 + k), {lk.err[8*k +: 8], lk.run[8*k +: 8]});
            rc(10'(238 + k), lk.dl0[16*k +: 16]);
            rc(10'(242 + k), lk.dl1[16*k +: 16]);
         end
         rc(10'h0fd, {lk.spec_err, lk.grp2_err, 14'h0000});
         rc(10'h108, {12'h000, ex.serial_err});
      end
      v = 16'($urandom);
      w = 16'($urandom);
      lk.done_code <= v;
      lk.done <= 2'b01;
      @(posedge pclk);
      lk.done_code <= w;
      lk.done <= 2'b10;
      @(posedge pclk);
      lk.done <= 2'b00;
      @(posedge pclk);
      rc(10'h0ed, {w[15:8], v[7:0]});
      for (int k = 0; k < 5; k++) begin
         ex.arith_set <= 5'(1 << k);
         @(posedge pclk);
         ex.arith_set <= 5'h00;
         apb(1'b0, 10'h0ff, 16'h0000, rd, err, n);
         chk(rd & 16'hfff8, 16'(8 << k));
         ex.end_of_program <= 1'b1;
         if (k == 4) ex.arith_set <= 5'h01;
         @(posedge pclk);
         ex.end_of_program <= 1'b0;
         ex.arith_set <= 5'h00;
         apb(1'b0, 10'h0ff, 16'h0000, rd, err, n);
         chk(rd & 16'hfff8, k == 4 ? 16'h0008 : 16'h0000);
      end
      mx = 16'h0000;
      mn = 16'h0000;
      for (int k = 0; k < 3; k++) begin
         u = k == 0 ? 5 : k == 1 ? 2 : 9;
         v = k == 0 ? 16'd37 : k == 1 ? 16'd99 : 16'd255;
         ex.irq_id <= v[7:0];
         ex.irq_active <= 1'b1;
         repeat (UNIT * u + 2) @(posedge pclk);
         ex.irq_active <= 1'b0;
         if (u > mx) begin
            mx = 16'(u);
            mn = 16'h8000 | bcd(v[7:0]);
         end
         repeat (3) @(posedge pclk);
         rc(10'h106, mx);
         rc(10'h107, mn);
      end
      rio.rack <= 3'($urandom);
      rio.master <= 8'($urandom);
      rio.fault <= 1'b1;
      @(posedge pclk);
      rio.fault <= 1'b0;
      @(posedge pclk);
      rc(10'h0fb, {rio.master, 1'b0, rio.rack, 4'h8});
      rio.rack <= ~rio.rack;
      rio.master <= ~rio.master;
      @(posedge pclk);
      apb(1'b1, 10'h0fb, 16'hffff, rd, err, n);
      repeat (2) @(posedge pclk);
      rc(10'h0fb, {rio.master, 1'b0, rio.rack, 4'h8});
      for (int k = 0; k < 3; k++) begin
         w = k == 0 ? 16'h0001 : k == 1 ? 16'h8000 : 16'(1 << ($urandom % 16));
         seen = 16'h0000;
         pulses = 0;
         apb(1'b1, 10'h12a, w, rd, err, n);
         rc(10'h12a, w);
         chk(seen, 16'h0000);
         apb(1'b1, 10'h12a, 16'h0000, rd, err, n);
         repeat (3) @(posedge pclk);
         chk(seen, w);
         chk(16'(pulses), 16'd1);
      end
      tg = '{0, 0, 0};
      hi = 0;
      apb(1'b0, 10'h0ff, 16'h0000, rd, err, n);
      last = rd[2:0];
      t0 = int'($time);
      repeat (400) begin
         apb(1'b0, 10'h0ff, 16'h0000, rd, err, n);
         for (int b = 0; b < 3; b++) tg[b] += int'(rd[b] != last[b]);
         hi += int'(rd[2]);
         last = rd[2:0];
      end
      t0 = (int'($time) - t0) / 10 / TICK;
      chk(near(tg[0], t0, 1), 16'h0001);
      chk(near(tg[1], t0 / 2, 1), 16'h0001);
      chk(near(tg[2], t0 / 10, 1), 16'h0001);
      chk(near(2 * hi, 400, 6), 16'h0001);
      print_verdict();
   end
endmodule : tb
